// [logic/reader_command_sequencer_tx.sv]
// Reader device end: boot, idle and transmit command sequencer with FIFO
`default_nettype none
module reader_command_sequencer_tx (
  input wire logic clock,
  input wire logic reset,
  input wire logic resetPowerdownPin,
  reader_link_if.device link,
  output logic txBit,
  output logic txActive
);
  reader_pkg::dev_state_t state_q;
  reader_pkg::dev_state_t state_d;
  logic [2:0] pinSync_q;
  logic pinLvl_q;
  logic bootReq;
  logic booting;
  logic bootDone;
  logic [15:0] bootCnt_q;
  logic [15:0] bitCnt_q;
  logic tick;
  logic [7:0] fifoMem [64];
  logic [5:0] wrPtr_q;
  logic [5:0] rdPtr_q;
  logic [6:0] level_q;
  logic fifoEmpty;
  logic fifoFull;
  logic hostWr;
  logic hostRd;
  logic push;
  logic pop;
  logic hostPop;
  logic txPop;
  logic ldCrc;
  logic advance;
  logic txEnd;
  logic cmdWr;
  logic [5:0] cmd_q;
  logic [7:0] redund_q;
  logic [2:0] lastBits_q;
  logic [1:0] irq_q;
  logic [7:0] sh_q;
  logic [3:0] bitsLeft_q;
  logic partial_q;
  logic inCrc_q;
  logic crcLeft_q;
  logic par_q;
  logic [15:0] crc_q;
  logic [15:0] crcBit;
  logic [15:0] crcSrc;
  logic lastByte;
  logic [2:0] phase;

  assign booting = state_q == reader_pkg::ST_BOOT;
  assign bootDone = booting && bootCnt_q == 16'h0000;
  assign fifoEmpty = level_q == 7'h00;
  assign fifoFull = level_q == reader_pkg::FIFO_DEPTH;
  assign tick = bitCnt_q == 16'h0000;
  // Boot ignores every access except status reads
  assign hostWr = link.regWrite && !booting;
  assign hostRd = link.regRead;
  assign cmdWr = hostWr && link.regAddr == reader_pkg::ADDR_CMD;
  assign push = hostWr && link.regAddr == reader_pkg::ADDR_FIFO && !fifoFull;
  assign hostPop = hostRd && !booting && !fifoEmpty && !txPop &&
    link.regAddr == reader_pkg::ADDR_FIFO;
  assign pop = hostPop || txPop;
  // A byte is the last one only if the host is not refilling right now
  assign lastByte = level_q == 7'h01 && !push && lastBits_q != 3'h0;

  // Pin filter: change counts once second and third stages agree
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pinSync_q <= 3'h7;
      pinLvl_q <= 1'b1;
    end else begin
      pinSync_q <= {pinSync_q[1:0], resetPowerdownPin};
      if (pinSync_q[1] == pinSync_q[2]) begin
        pinLvl_q <= pinSync_q[2];
      end
    end
  end
  assign bootReq = pinLvl_q && !pinSync_q[1] && !pinSync_q[2];

  // Check sum of one more data bit, LSB first
  always_comb begin
    crcBit = {1'b0, crc_q[15:1]};
    if (crc_q[0] ^ sh_q[0]) begin
      crcBit = crcBit ^ reader_pkg::CRC_POLY;
    end
    crcSrc = state_q == reader_pkg::ST_DATA && !inCrc_q ? crcBit : crc_q;
  end

  // Sequencer next state and datapath actions
  always_comb begin
    state_d = state_q;
    txPop = 1'b0;
    ldCrc = 1'b0;
    advance = 1'b0;
    txEnd = 1'b0;
    case (state_q)
      reader_pkg::ST_BOOT: begin
        if (bootDone) begin
          state_d = reader_pkg::ST_IDLE;
        end
      end
      reader_pkg::ST_ARMED: begin
        if (!fifoEmpty) begin
          state_d = reader_pkg::ST_SOF;
        end
      end
      reader_pkg::ST_SOF: begin
        if (tick) begin
          state_d = fifoEmpty ? reader_pkg::ST_EOF : reader_pkg::ST_DATA;
          txPop = !fifoEmpty;
        end
      end
      reader_pkg::ST_DATA: begin
        if (tick && bitsLeft_q == 4'h1) begin
          if (partial_q) begin
            state_d = reader_pkg::ST_EOF;
          end else if (redund_q[reader_pkg::RED_PAR_EN]) begin
            state_d = reader_pkg::ST_PAR;
          end else begin
            advance = 1'b1;
          end
        end
      end
      reader_pkg::ST_PAR: begin
        advance = tick;
      end
      reader_pkg::ST_EOF: begin
        if (tick) begin
          state_d = reader_pkg::ST_IDLE;
          txEnd = 1'b1;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
    // Next byte: FIFO first, then check sum, else close the frame
    if (advance) begin
      if (inCrc_q) begin
        state_d = crcLeft_q ? reader_pkg::ST_DATA : reader_pkg::ST_EOF;
        ldCrc = crcLeft_q;
      end else if (!fifoEmpty) begin
        state_d = reader_pkg::ST_DATA;
        txPop = 1'b1;
      end else if (redund_q[reader_pkg::RED_CRC_EN]) begin
        state_d = reader_pkg::ST_DATA;
        ldCrc = 1'b1;
      end else begin
        state_d = reader_pkg::ST_EOF;
      end
    end
    // Host command writes; a repeated transmit code is ignored
    if (cmdWr) begin
      if (link.regWdata[5:0] == reader_pkg::CMD_TX) begin
        if (state_q == reader_pkg::ST_IDLE) begin
          state_d = fifoEmpty ? reader_pkg::ST_ARMED
                              : reader_pkg::ST_SOF;
        end
      end else begin
        state_d = reader_pkg::ST_IDLE;
        txPop = 1'b0;
        ldCrc = 1'b0;
        txEnd = 1'b0;
      end
    end
  end

  // Sequencer state and boot timer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= reader_pkg::ST_BOOT;
      bootCnt_q <= 16'(reader_pkg::BOOT_CYCLES - 1);
    end else if (bootReq) begin
      state_q <= reader_pkg::ST_BOOT;
      bootCnt_q <= 16'(reader_pkg::BOOT_CYCLES - 1);
    end else begin
      state_q <= state_d;
      if (booting && !bootDone) begin
        bootCnt_q <= bootCnt_q - 16'h0001;
      end
    end
  end

  // Bit timer runs in every state except idle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bitCnt_q <= 16'h0000;
    end else if (state_d != state_q || tick ||
        state_q == reader_pkg::ST_IDLE) begin
      bitCnt_q <= 16'(reader_pkg::BIT_CYCLES - 1);
    end else begin
      bitCnt_q <= bitCnt_q - 16'h0001;
    end
  end

  // Shift register, parity and check sum
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sh_q <= 8'h00;
      bitsLeft_q <= 4'h0;
      partial_q <= 1'b0;
      inCrc_q <= 1'b0;
      crcLeft_q <= 1'b0;
      par_q <= 1'b0;
      crc_q <= reader_pkg::CRC_PRESET;
    end else if (state_q == reader_pkg::ST_IDLE ||
        state_q == reader_pkg::ST_ARMED) begin
      inCrc_q <= 1'b0;
      crc_q <= reader_pkg::CRC_PRESET;
    end else if (txPop) begin
      sh_q <= fifoMem[rdPtr_q];
      bitsLeft_q <= lastByte ? {1'b0, lastBits_q} : 4'h8;
      partial_q <= lastByte;
      par_q <= 1'b0;
      if (state_q == reader_pkg::ST_DATA && !inCrc_q) begin
        crc_q <= crcBit;
      end
    end else if (ldCrc) begin
      sh_q <= inCrc_q ? crcSrc[15:8] : crcSrc[7:0];
      crcLeft_q <= !inCrc_q;
      inCrc_q <= 1'b1;
      bitsLeft_q <= 4'h8;
      partial_q <= 1'b0;
      par_q <= 1'b0;
      if (state_q == reader_pkg::ST_DATA && !inCrc_q) begin
        crc_q <= crcBit;
      end
    end else if (state_q == reader_pkg::ST_DATA && tick) begin
      sh_q <= {1'b0, sh_q[7:1]};
      bitsLeft_q <= bitsLeft_q - 4'h1;
      par_q <= par_q ^ sh_q[0];
      if (!inCrc_q) begin
        crc_q <= crcBit;
      end
    end
  end

  // Line output, one cycle behind the sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      txBit <= 1'b0;
      txActive <= 1'b0;
    end else begin
      txActive <= state_q == reader_pkg::ST_SOF ||
        state_q == reader_pkg::ST_DATA || state_q == reader_pkg::ST_PAR ||
        state_q == reader_pkg::ST_EOF;
      case (state_q)
        reader_pkg::ST_SOF: txBit <= 1'b1;
        reader_pkg::ST_DATA: txBit <= sh_q[0];
        reader_pkg::ST_PAR:
          txBit <= par_q ^ redund_q[reader_pkg::RED_PAR_ODD];
        default: txBit <= 1'b0;
      endcase
    end
  end

  // FIFO storage; aborts never touch it, boot empties it
  always_ff @(posedge clock) begin
    if (push) begin
      fifoMem[wrPtr_q] <= link.regWdata;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wrPtr_q <= 6'h00;
      rdPtr_q <= 6'h00;
      level_q <= 7'h00;
    end else if (bootReq) begin
      wrPtr_q <= 6'h00;
      rdPtr_q <= 6'h00;
      level_q <= 7'h00;
    end else begin
      wrPtr_q <= wrPtr_q + {5'h00, push};
      rdPtr_q <= rdPtr_q + {5'h00, pop};
      level_q <= level_q + {6'h00, push} - {6'h00, pop};
    end
  end

  // Configuration, command and flag registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmd_q <= reader_pkg::CMD_BOOT;
      redund_q <= reader_pkg::REDUND_RESET;
      lastBits_q <= reader_pkg::LASTBITS_RESET;
      irq_q <= 2'h0;
    end else if (bootReq) begin
      cmd_q <= reader_pkg::CMD_BOOT;
      redund_q <= reader_pkg::REDUND_RESET;
      lastBits_q <= reader_pkg::LASTBITS_RESET;
      irq_q <= 2'h0;
    end else if (bootDone) begin
      cmd_q <= reader_pkg::CMD_IDLE;
      redund_q <= reader_pkg::EE_REDUND;
      lastBits_q <= reader_pkg::EE_FRAME[2:0];
      irq_q[reader_pkg::IRQ_CMD_DONE] <= 1'b1;
    end else begin
      if (hostWr && link.regAddr == reader_pkg::ADDR_REDUND) begin
        redund_q <= link.regWdata;
      end
      if (cmdWr && state_d == reader_pkg::ST_IDLE) begin
        cmd_q <= reader_pkg::CMD_IDLE;
      end else if (cmdWr && state_q == reader_pkg::ST_IDLE) begin
        cmd_q <= reader_pkg::CMD_TX;
      end else if (txEnd) begin
        cmd_q <= reader_pkg::CMD_IDLE;
      end
      // End of frame clears the bit count even over a host write
      if (txEnd) begin
        lastBits_q <= 3'h0;
      end else if (hostWr && link.regAddr == reader_pkg::ADDR_FRAME) begin
        lastBits_q <= link.regWdata[2:0];
      end
      // Write one to clear; a set in the same cycle wins
      irq_q <= (irq_q & ~((hostWr && link.regAddr == reader_pkg::ADDR_IRQ)
        ? link.regWdata[1:0] : 2'h0)) | {txEnd, txEnd};
    end
  end

  // Phase code for status
  always_comb begin
    case (state_q)
      reader_pkg::ST_BOOT: phase = reader_pkg::PH_BOOT;
      reader_pkg::ST_ARMED: phase = reader_pkg::PH_ARMED;
      reader_pkg::ST_SOF: phase = reader_pkg::PH_SOF;
      reader_pkg::ST_DATA: phase = reader_pkg::PH_DATA;
      reader_pkg::ST_PAR: phase = reader_pkg::PH_PAR;
      reader_pkg::ST_EOF: phase = reader_pkg::PH_EOF;
      default: phase = reader_pkg::PH_IDLE;
    endcase
  end

  // Read answers one cycle after the request; unmapped reads return zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      link.regRvalid <= 1'b0;
      link.regRdata <= 8'h00;
    end else begin
      link.regRvalid <= hostRd;
      link.regRdata <= 8'h00;
      if (hostRd && link.regAddr == reader_pkg::ADDR_STATUS) begin
        link.regRdata <= {2'h0, booting, fifoFull, fifoEmpty, phase};
      end else if (hostRd && !booting) begin
        if (link.regAddr == reader_pkg::ADDR_CMD) begin
          link.regRdata <= {2'h0, cmd_q};
        end else if (hostPop) begin
          link.regRdata <= fifoMem[rdPtr_q];
        end else if (link.regAddr == reader_pkg::ADDR_LEVEL) begin
          link.regRdata <= {1'b0, level_q};
        end else if (link.regAddr == reader_pkg::ADDR_IRQ) begin
          link.regRdata <= {6'h00, irq_q};
        end else if (link.regAddr == reader_pkg::ADDR_FRAME) begin
          link.regRdata <= {5'h00, lastBits_q};
        end else if (link.regAddr == reader_pkg::ADDR_REDUND) begin
          link.regRdata <= redund_q;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [shared/reader_pkg.sv]
// Shared constants and types for the reader command sequencer and its host
`default_nettype none
package reader_pkg;
  // Command codes
  localparam logic [5:0] CMD_IDLE = 6'h00;
  localparam logic [5:0] CMD_TX = 6'h1a;
  localparam logic [5:0] CMD_BOOT = 6'h3f;
  // Device register addresses on the link
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_CMD = 6'h01;
  localparam logic [5:0] ADDR_FIFO = 6'h02;
  localparam logic [5:0] ADDR_LEVEL = 6'h04;
  localparam logic [5:0] ADDR_IRQ = 6'h07;
  localparam logic [5:0] ADDR_FRAME = 6'h0f;
  localparam logic [5:0] ADDR_REDUND = 6'h22;
  // Field positions
  localparam int RED_PAR_EN = 0;
  localparam int RED_PAR_ODD = 1;
  localparam int RED_CRC_EN = 2;
  localparam int IRQ_CMD_DONE = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int STS_FIFO_EMPTY = 3;
  localparam int STS_FIFO_FULL = 4;
  localparam int STS_BOOTING = 5;
  // Reset values and stored boot image
  localparam logic [7:0] REDUND_RESET = 8'h00;
  localparam logic [2:0] LASTBITS_RESET = 3'h0;
  localparam logic [7:0] EE_REDUND = 8'h03;
  localparam logic [7:0] EE_FRAME = 8'h00;
  // Line phase codes
  localparam logic [2:0] PH_IDLE = 3'h0;
  localparam logic [2:0] PH_ARMED = 3'h1;
  localparam logic [2:0] PH_SOF = 3'h2;
  localparam logic [2:0] PH_DATA = 3'h3;
  localparam logic [2:0] PH_PAR = 3'h4;
  localparam logic [2:0] PH_EOF = 3'h5;
  localparam logic [2:0] PH_BOOT = 3'h7;
  // FIFO and check sums
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam logic [15:0] CRC_PRESET = 16'h6363;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int BIT_TIME_NS = 10000;
  localparam int BIT_CYCLES = BIT_TIME_NS * CLK_MHZ / 1000;
  localparam int BOOT_TIME_NS = 5000;
  localparam int BOOT_CYCLES = BOOT_TIME_NS * CLK_MHZ / 1000;
  // Controller register map (AXI4-Lite byte addresses)
  localparam logic [31:0] CSR_CTRL = 32'h0000_0000;
  localparam logic [31:0] CSR_STAT = 32'h0000_0004;
  localparam int CTRL_RD_BIT = 16;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    ST_BOOT = 7'h01,
    ST_IDLE = 7'h02,
    ST_ARMED = 7'h04,
    ST_SOF = 7'h08,
    ST_DATA = 7'h10,
    ST_PAR = 7'h20,
    ST_EOF = 7'h40
  } dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_POLLW = 4'h2,
    H_PREW = 4'h4,
    H_RDW = 4'h8
  } host_state_t;
endpackage
`default_nettype wire

// [shared/reader_link_if.sv]
// Register port between the host controller and the reader device
`default_nettype none
interface reader_link_if;
  logic regWrite;
  logic regRead;
  logic [5:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic regRvalid;
  modport device (
    input regWrite,
    input regRead,
    input regAddr,
    input regWdata,
    output regRdata,
    output regRvalid
  );
  modport host (
    output regWrite,
    output regRead,
    output regAddr,
    output regWdata,
    input regRdata,
    input regRvalid
  );
endinterface
`default_nettype wire

// [logic/reader_host_controller.sv]
// Host end: AXI4-Lite command registers driving the reader register port
`default_nettype none
module reader_host_controller (
  input wire logic clock,
  input wire logic reset,
  reader_link_if.host link,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  reader_pkg::host_state_t state_q;
  logic awHave_q;
  logic wHave_q;
  logic [31:0] awAddr_q;
  logic [31:0] wData_q;
  logic start;
  logic reqRd_q;
  logic [5:0] reqAddr_q;
  logic [7:0] reqData_q;
  logic [7:0] shadowRed_q;
  logic [7:0] rdData_q;
  logic needPre;

  assign start = awHave_q && wHave_q && !bvalid &&
    awAddr_q == reader_pkg::CSR_CTRL && state_q == reader_pkg::H_IDLE;
  // A partial final byte needs the check sum switched off first
  assign needPre = !reqRd_q && reqAddr_q == reader_pkg::ADDR_FRAME &&
    reqData_q[2:0] != 3'h0 && shadowRed_q[reader_pkg::RED_CRC_EN];

  // Write channel: address and data taken in either order
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 32'h0000_0000;
      wData_q <= 32'h0000_0000;
      bvalid <= 1'b0;
      bresp <= reader_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr_q <= awaddr;
        awready <= 1'b0;
        awHave_q <= 1'b1;
      end
      if (wvalid && wready) begin
        wData_q <= wdata;
        wready <= 1'b0;
        wHave_q <= 1'b1;
      end
      if (awHave_q && wHave_q && !bvalid) begin
        bvalid <= 1'b1;
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bresp <= awAddr_q == reader_pkg::CSR_CTRL ? reader_pkg::RESP_OKAY
                                                 : reader_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= reader_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= reader_pkg::RESP_OKAY;
      if (araddr == reader_pkg::CSR_STAT) begin
        rdata <= {16'h0000, rdData_q, 7'h00, state_q != reader_pkg::H_IDLE};
      end else if (araddr == reader_pkg::CSR_CTRL) begin
        rdata <= {15'h0000, reqRd_q, 2'h0, reqAddr_q, reqData_q};
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= reader_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Access sequencer: poll status until boot is over, then access
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= reader_pkg::H_IDLE;
      reqRd_q <= 1'b0;
      reqAddr_q <= 6'h00;
      reqData_q <= 8'h00;
      shadowRed_q <= reader_pkg::REDUND_RESET;
      rdData_q <= 8'h00;
      link.regWrite <= 1'b0;
      link.regRead <= 1'b0;
      link.regAddr <= 6'h00;
      link.regWdata <= 8'h00;
    end else begin
      link.regWrite <= 1'b0;
      link.regRead <= 1'b0;
      case (state_q)
        reader_pkg::H_IDLE: begin
          if (start) begin
            reqRd_q <= wData_q[reader_pkg::CTRL_RD_BIT];
            reqAddr_q <= wData_q[reader_pkg::CTRL_ADDR_LSB +: 6];
            reqData_q <= wData_q[7:0];
            link.regRead <= 1'b1;
            link.regAddr <= reader_pkg::ADDR_STATUS;
            state_q <= reader_pkg::H_POLLW;
          end
        end
        reader_pkg::H_POLLW: begin
          if (link.regRvalid) begin
            if (link.regRdata[reader_pkg::STS_BOOTING]) begin
              link.regRead <= 1'b1;
            end else if (needPre) begin
              link.regWrite <= 1'b1;
              link.regAddr <= reader_pkg::ADDR_REDUND;
              link.regWdata <= shadowRed_q &
                ~(8'h01 << reader_pkg::RED_CRC_EN);
              shadowRed_q[reader_pkg::RED_CRC_EN] <= 1'b0;
              state_q <= reader_pkg::H_PREW;
            end else begin
              // FIFO bytes pass at once to keep a running frame fed
              link.regWrite <= !reqRd_q;
              link.regRead <= reqRd_q;
              link.regAddr <= reqAddr_q;
              link.regWdata <= reqData_q;
              if (!reqRd_q && reqAddr_q == reader_pkg::ADDR_REDUND) begin
                shadowRed_q <= reqData_q;
              end
              state_q <= reqRd_q ? reader_pkg::H_RDW : reader_pkg::H_IDLE;
            end
          end
        end
        reader_pkg::H_PREW: begin
          link.regWrite <= 1'b1;
          link.regAddr <= reqAddr_q;
          link.regWdata <= reqData_q;
          state_q <= reader_pkg::H_IDLE;
        end
        reader_pkg::H_RDW: begin
          if (link.regRvalid) begin
            rdData_q <= link.regRdata;
            state_q <= reader_pkg::H_IDLE;
          end
        end
        default: begin
          state_q <= reader_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [verif/reader_command_sequencer_tx_asserts.sv]
// Link and serial line checks for the reader pair
`default_nettype none
module reader_command_sequencer_tx_asserts (
  input wire logic clock,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regRvalid,
  input wire logic txBit,
  input wire logic txActive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] bootCnt_q;
  logic abortWr;
  // Idle code written to the command register
  assign abortWr = regWrite && regAddr == reader_pkg::ADDR_CMD
    && regWdata == 8'h00;
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // Boot window; writes inside it would be silently lost by the device
  always_ff @(posedge clock or posedge reset) begin
    if (reset)
      bootCnt_q <= 8'h00;
    else if (bootCnt_q < reader_pkg::BOOT_CYCLES)
      bootCnt_q <= bootCnt_q + 8'h01;
  end
  // Link answers, framing and abort timing
  a_no_boot_write: assert property (
    bootCnt_q < reader_pkg::BOOT_CYCLES |-> !regWrite)
    else $error("write during boot");
  a_one_access: assert property (!(regWrite && regRead))
    else $error("read and write together");
  a_read_answer: assert property (regRead |=> regRvalid)
    else $error("read not answered");
  a_answer_cause: assert property (regRvalid |-> $past(regRead))
    else $error("answer without read");
  a_sof_mark: assert property ($rose(txActive) |-> txBit[*8])
    else $error("frame start not high");
  a_line_rest: assert property (
    !txActive ##1 !txActive |-> !txBit)
    else $error("line not low outside frame");
  a_abort_stop: assert property (
    txActive && abortWr |-> ##[1:2] !txActive)
    else $error("abort did not halt");
  a_abort_quiet: assert property (abortWr |-> ##3 !txActive[*4])
    else $error("line restarted after abort");
  a_start_cause: assert property (
    $rose(txActive) |-> $past(regWrite, 2) || $past(regWrite, 3))
    else $error("frame without host write");
  cover property ($rose(txActive));
  cover property (txActive && abortWr);
  cover property (regRvalid);
endmodule
`default_nettype wire

// [verif/tb_reader_command_sequencer_tx.sv]
// Bench for the reader pair: AXI side driven, serial line watched
`default_nettype none
module tb_reader_command_sequencer_tx;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset = 1'b1, resetPowerdownPin = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, txBit, txActive;
  logic [31:0] rdata, s;
  logic [1:0] bresp, rresp, r;
  logic [31:0] frame;
  logic [7:0] v, l1;
  int nbits, failures, checked, cycles;
  reader_link_if link();
  reader_command_sequencer_tx u_reader_command_sequencer_tx (.clock,
    .reset, .resetPowerdownPin, .link, .txBit, .txActive);
  reader_host_controller u_reader_host_controller (.clock, .reset, .link,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf),
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp);
  reader_command_sequencer_tx_asserts u_reader_command_sequencer_tx_asserts (
    .clock, .reset, .regWrite(link.regWrite), .regRead(link.regRead),
    .regAddr(link.regAddr), .regWdata(link.regWdata),
    .regRvalid(link.regRvalid), .txBit, .txActive);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      conclude();
    end
  end
  // Sample each line bit at its middle, SOF at index 0
  always @(posedge txActive) begin
    nbits = 0;
    frame = 32'h0;
    repeat (reader_pkg::BIT_CYCLES / 2) @(posedge clock);
    while (txActive === 1'b1) begin
      frame[nbits] = txBit;
      nbits++;
      repeat (reader_pkg::BIT_CYCLES) @(posedge clock);
    end
  end
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    s = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Device access through the controller; busy must clear before reuse
  task automatic dev(input logic rd, input logic [5:0] a, input logic [7:0] d);
    axw(reader_pkg::CSR_CTRL, {15'h0000, rd, 2'h0, a, d});
    do axr(reader_pkg::CSR_STAT); while (s[0] !== 1'b0);
    v = s[15:8];
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    dev(1'b0, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    dev(1'b1, a, 8'h00);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Frame end plus one bit time so the sampler has finished
  task automatic fin();
    @(negedge txActive);
    repeat (reader_pkg::BIT_CYCLES) @(posedge clock);
  endtask
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rd(reader_pkg::ADDR_CMD);
    chk("command", 8'h00, v);
    rd(reader_pkg::ADDR_REDUND);
    chk("redundancy", reader_pkg::EE_REDUND, v);
    rd(reader_pkg::ADDR_IRQ);
    chk("flags", 8'h01, v);
    axr(32'h0000_0010);
    chk("response", reader_pkg::RESP_SLVERR, r);
    axw(32'h0000_0010, 32'h0000_0000);
    chk("bresp", reader_pkg::RESP_SLVERR, r);
    wr(reader_pkg::ADDR_IRQ, 8'h03);
    wr(reader_pkg::ADDR_REDUND, 8'h00);
    wr(reader_pkg::ADDR_CMD, {2'h0, reader_pkg::CMD_TX});
    rd(reader_pkg::ADDR_STATUS);
    chk("phase", reader_pkg::PH_ARMED, v[2:0]);
    wr(reader_pkg::ADDR_FIFO, 8'ha5);
    fin();
    chk("frame", {6'h00, 1'b0, 8'ha5, 1'b1}, frame[15:0]);
    chk("bits", 16'h000a, nbits[15:0]);
    rd(reader_pkg::ADDR_IRQ);
    chk("flags", 8'h03, v);
    rd(reader_pkg::ADDR_CMD);
    chk("command", 8'h00, v);
    // Parity on, partial last byte of three bits
    wr(reader_pkg::ADDR_IRQ, 8'h03);
    wr(reader_pkg::ADDR_REDUND, 8'h01);
    wr(reader_pkg::ADDR_FRAME, 8'h03);
    wr(reader_pkg::ADDR_FIFO, 8'h01);
    wr(reader_pkg::ADDR_FIFO, 8'h5c);
    wr(reader_pkg::ADDR_CMD, 8'h1a);
    fin();
    chk("frame", {2'h0, 1'b0, 3'h4, 1'b1, 8'h01, 1'b1}, frame[15:0]);
    chk("bits", 16'h000e, nbits[15:0]);
    rd(reader_pkg::ADDR_FRAME);
    chk("count", 8'h00, {5'h00, v[2:0]});
    // Sum on, one zero byte: sum from the preset, low byte first
    wr(reader_pkg::ADDR_REDUND, 8'h04);
    wr(reader_pkg::ADDR_FIFO, 8'h00);
    wr(reader_pkg::ADDR_CMD, 8'h1a);
    fin();
    chk("sum", 16'h51fe, frame[24:9]);
    chk("bits", 16'h001a, nbits[15:0]);
    // Nonzero bit count: host switches the sum off first
    wr(reader_pkg::ADDR_FRAME, 8'h02);
    rd(reader_pkg::ADDR_REDUND);
    chk("redundancy", 8'h00, v);
    // Abort during the frame start mark with all three bytes still queued
    wr(reader_pkg::ADDR_IRQ, 8'h03);
    for (int i = 0; i < 3; i++) wr(reader_pkg::ADDR_FIFO, 8'h11);
    wr(reader_pkg::ADDR_CMD, 8'h1a);
    rd(reader_pkg::ADDR_LEVEL);
    l1 = v;
    chk("level", 8'h03, l1);
    wr(reader_pkg::ADDR_CMD, 8'h00);
    rd(reader_pkg::ADDR_LEVEL);
    chk("level", l1, v);
    rd(reader_pkg::ADDR_IRQ);
    chk("flags", 8'h00, v);
    rd(reader_pkg::ADDR_CMD);
    chk("command", 8'h00, v);
    // Pin-triggered boot empties the queue and reloads the image
    resetPowerdownPin <= 1'b0;
    repeat (10) @(posedge clock);
    resetPowerdownPin <= 1'b1;
    rd(reader_pkg::ADDR_LEVEL);
    chk("level", 8'h00, v);
    rd(reader_pkg::ADDR_REDUND);
    chk("redundancy", reader_pkg::EE_REDUND, v);
    conclude();
  end
endmodule
`default_nettype wire
